// ---- slb_far_end.sv ----
// Behavioural far-end serializer: recovered link clock, received word and lock.
module slb_far_end (
	input wire logic run,
	input wire logic lock_in,
	input wire logic [23:0] err_mask,
	output logic link_clock,
	output logic [23:0] rx_word,
	output logic rx_lock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] gen = 24'h3c96e1;
	function automatic logic [23:0] nx(input logic [23:0] s);
		for (int i = 0; i < 24; i++) s = {s[22:0], ^(s & slb_pkg::LFSR_TAPS)};
		return s;
	endfunction
	assign rx_lock = lock_in;
	////////////////////////////////////////
	// The clock stands still between runs, and the idle word keeps toggling so no stale value looks valid.
	initial begin
		link_clock = 1'b0;
		rx_word = 24'h0;
		#7;
		forever begin
			#160;
			if (run) link_clock = ~link_clock;
			else rx_word = ~rx_word;
		end
	end
	// A word is also put out as the clock starts, so the first rising edge never carries an idle word.
	always @(negedge link_clock or posedge run) begin
		if (run) begin
			gen = nx(gen);
			rx_word = gen ^ err_mask;
		end
	end
endmodule // slb_far_end

// ---- slb_lfsr.sv ----
// Word-wide pattern generator register with load and advance controls.
module slb_lfsr (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [slb_pkg::WORD_W-1:0] load_value,
	input wire logic advance,
	output logic [slb_pkg::WORD_W-1:0] word
);
	import slb_pkg::*;

	// An all-zero state would lock the generator, so such a load falls back to the seed.
	wire logic [WORD_W-1:0] safe_value = (load_value == '0) ? LFSR_SEED : load_value;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			word <= LFSR_SEED;
		end else if (load) begin
			word <= safe_value;
		end else if (advance) begin
			word <= slb_step(word);
		end
	end

endmodule // slb_lfsr

// ---- slb_pkg.sv ----
// Shared constants, types and helper functions for the link self-test block.
package slb_pkg;

	localparam int WORD_W = 24;
	localparam int BANK_W = 8;
	localparam int NUM_BANKS = 3;
	localparam int CNT_W = 8;
	localparam int IRQ_W = 3;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int SYNC_STAGES = 2;

	// Generator seed and feedback taps for x^24 + x^23 + x^22 + x^17 + 1.
	// The seed value is arbitrary; it only has to be non-zero and the same at both ends.
	localparam logic [WORD_W-1:0] LFSR_SEED = 24'h5a5a5a;
	localparam logic [WORD_W-1:0] LFSR_TAPS = 24'he10000;

	localparam logic [CNT_W-1:0] ERR_CNT_MAX = 8'hff;

	// A ratio of one error in ten to the ninth bits, expressed in error-free words.
	localparam longint BER_BITS = 64'd1000000000;
	localparam int PASS_WORDS = int'((BER_BITS + WORD_W - 1) / WORD_W);

	// Stagger delays in pipeline steps of one system clock each.
	localparam int STAGGER_PIPE = 4;
	localparam logic [1:0] FIXED_DELAY_FIRST = 2'h2;
	localparam logic [1:0] FIXED_DELAY_OTHER = 2'h1;
	localparam logic [1:0] RCLK_DELAY_FIXED = 2'h0;
	localparam logic [1:0] RCLK_DELAY_SPREAD = 2'h3;
	localparam logic [1:0] SPREAD_WORDS_LAST = 2'h3;
	localparam logic [1:0] ROT_LAST = 2'h2;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h000;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 12'h008;
	localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 12'h00c;
	localparam logic [ADDR_W-1:0] REG_PASS_WORDS = 12'h010;

	// Status and interrupt field positions.
	localparam int ST_PASS = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_TEST = 2;
	localparam int ST_CNT_LSB = 8;
	localparam int IRQ_PASS = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_LOCK_LOST = 2;

	typedef enum logic [1:0] {CHK_OFF, CHK_SYNC, CHK_RUN} slb_chk_t;

	// Advances the generator by one whole word.
	function automatic logic [WORD_W-1:0] slb_step(input logic [WORD_W-1:0] s);
		logic [WORD_W-1:0] r;
		r = s;
		for (int i = 0; i < WORD_W; i++) begin
			r = {r[WORD_W-2:0], ^(r & LFSR_TAPS)};
		end
		return r;
	endfunction

	function automatic logic [CNT_W:0] slb_popcount(input logic [WORD_W-1:0] v);
		logic [CNT_W:0] n;
		n = '0;
		for (int i = 0; i < WORD_W; i++) begin
			n = n + {{CNT_W{1'b0}}, v[i]};
		end
		return n;
	endfunction

endpackage

// ---- slb_top.sv ----
// Link self-test, scrambling and staggered output logic of the serializer/deserializer pair.
//
// Operation
// - Self-test runs at the receiver while the self-test enable input and lock are both high and stops otherwise.
// - In self-test the transmitter sends the generated pattern instead of its parallel input.
// - The receiver checks the stream against its own copy of the pattern and reports mismatches on its outputs.
// - With error reporting low, each output flags a mismatch of its own bit for every word.
// - With error reporting high, errors add into an 8-bit counter saturating at 255 shown on the low eight outputs.
// - The pass output stays low and rises once the error ratio of one in ten to the ninth bits is achieved.
// - The pass output is only meaningful while the receiver is locked.
// - In fixed stagger mode the first bank switches two steps after the clock and the other two banks one step.
// - In spread stagger mode adjacent banks switch out of phase and the arrangement rotates every 4 words.
// - In spread stagger mode the recovered clock output is also offset one step from the data banks.
// - With scramble disable high both ends bypass scrambling, otherwise they scramble and descramble.
// - The parallel outputs are valid only while lock is high.
module slb_top #(
	parameter int PASS_WORDS_DEFAULT = slb_pkg::PASS_WORDS
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [slb_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [slb_pkg::DATA_W-1:0] pwdata,
	output logic [slb_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic transmit_clock,
	input wire logic [slb_pkg::WORD_W-1:0] parallel_in,
	output logic [slb_pkg::WORD_W-1:0] tx_word,
	input wire logic link_clock,
	input wire logic [slb_pkg::WORD_W-1:0] rx_word,
	input wire logic rx_lock,
	input wire logic self_test_enable,
	input wire logic error_report_select,
	input wire logic output_stagger_select,
	input wire logic scramble_disable,
	output logic [slb_pkg::WORD_W-1:0] parallel_out,
	output logic recovered_clock_out,
	output logic data_valid,
	output logic test_pass,
	output logic irq
);
	import slb_pkg::*;

	localparam int RXG_W = WORD_W + 6;
	localparam int TXG_W = WORD_W + 1;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic [RXG_W-1:0] rx_meta;
	logic [RXG_W-1:0] rx_sync;
	logic [TXG_W-1:0] tx_meta;
	logic [TXG_W-1:0] tx_sync;
	logic rx_clk_d;
	logic tx_clk_d;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rx_meta <= '0;
			rx_sync <= '0;
			tx_meta <= '0;
			tx_sync <= '0;
			rx_clk_d <= 1'b0;
			tx_clk_d <= 1'b0;
		end else begin
			rx_meta <= {link_clock, rx_lock, self_test_enable, error_report_select,
				output_stagger_select, scramble_disable, rx_word};
			rx_sync <= rx_meta;
			tx_meta <= {transmit_clock, parallel_in};
			tx_sync <= tx_meta;
			rx_clk_d <= rx_sync[RXG_W-1];
			tx_clk_d <= tx_sync[TXG_W-1];
		end
	end

	wire logic rx_clk_s = rx_sync[RXG_W-1];
	wire logic lock_s = rx_sync[RXG_W-2];
	wire logic test_s = rx_sync[RXG_W-3];
	wire logic count_mode_s = rx_sync[RXG_W-4];
	wire logic spread_s = rx_sync[RXG_W-5];
	wire logic descr_off_s = rx_sync[RXG_W-6];
	wire logic [WORD_W-1:0] rx_data_s = rx_sync[WORD_W-1:0];
	wire logic [WORD_W-1:0] tx_data_s = tx_sync[WORD_W-1:0];
	wire logic rx_edge = rx_clk_s & ~rx_clk_d;
	// The transmitter only advances on real clock edges, so a stopped clock stalls the pattern.
	wire logic tx_edge = tx_sync[TXG_W-1] & ~tx_clk_d;

	////////////////////////////////////////////////////////////////////////////
	// Transmit end.

	logic [WORD_W-1:0] tx_gen_word;
	wire logic [WORD_W-1:0] tx_pred = slb_step(tx_gen_word);
	// The scramble input is shared by both ends, as a single strap would be on a bench.
	wire logic [WORD_W-1:0] tx_plain = descr_off_s ? tx_data_s : (tx_data_s ^ tx_pred);
	wire logic [WORD_W-1:0] next_tx_word = test_s ? tx_pred : tx_plain;

	slb_lfsr u_tx_gen (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load(1'b0),
		.load_value(LFSR_SEED),
		.advance(tx_edge),
		.word(tx_gen_word)
	);

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tx_word <= '0;
		end else if (tx_edge) begin
			tx_word <= next_tx_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive checker.

	slb_chk_t chk_state;
	logic [WORD_W-1:0] rx_gen_word;
	logic [CNT_W-1:0] err_count;
	logic [31:0] good_words;
	logic [31:0] pass_words;
	logic pass;
	logic lock_d;

	wire logic [WORD_W-1:0] rx_pred = slb_step(rx_gen_word);
	wire logic checking = (chk_state == CHK_RUN);
	wire logic [WORD_W-1:0] err_bits = checking ? (rx_data_s ^ rx_pred) : '0;
	wire logic word_err = rx_edge & (|err_bits);
	wire logic [CNT_W:0] err_sum = {1'b0, err_count} + slb_popcount(err_bits);
	wire logic [CNT_W-1:0] next_err_count = err_sum[CNT_W] ? ERR_CNT_MAX : err_sum[CNT_W-1:0];
	wire logic lock_rise = lock_s & ~lock_d;
	wire logic lock_fall = ~lock_s & lock_d;
	wire logic gen_load = (lock_rise & ~test_s) | (rx_edge & (chk_state == CHK_SYNC));
	wire logic [WORD_W-1:0] gen_seed = test_s ? rx_data_s : LFSR_SEED;
	wire logic pass_hit = checking & ~pass & (good_words >= pass_words);
	wire logic [WORD_W-1:0] rx_plain = descr_off_s ? rx_data_s : (rx_data_s ^ rx_pred);
	wire logic [WORD_W-1:0] count_word = {{(WORD_W-CNT_W){1'b0}}, next_err_count};
	wire logic [WORD_W-1:0] test_word = count_mode_s ? count_word : err_bits;
	wire logic [WORD_W-1:0] next_staged = test_s ? test_word : rx_plain;

	slb_lfsr u_rx_gen (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load(gen_load),
		.load_value(gen_seed),
		.advance(rx_edge),
		.word(rx_gen_word)
	);

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			chk_state <= CHK_OFF;
		end else begin
			case (chk_state)
				CHK_OFF: if (test_s && lock_s) chk_state <= CHK_SYNC;
				CHK_SYNC: if (!test_s || !lock_s) chk_state <= CHK_OFF; else if (rx_edge) chk_state <= CHK_RUN;
				CHK_RUN: if (!test_s || !lock_s) chk_state <= CHK_OFF;
				default: chk_state <= CHK_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n || !checking) begin
			err_count <= '0;
			good_words <= '0;
		end else if (rx_edge) begin
			err_count <= next_err_count;
			good_words <= word_err ? '0 : good_words + 32'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n || !checking) begin
			pass <= 1'b0;
		end else if (pass_hit) begin
			pass <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Staggered output banks.

	logic [WORD_W-1:0] staged;
	logic [STAGGER_PIPE-1:0] stb;
	logic [STAGGER_PIPE-1:0] clk_pipe;
	logic [1:0] word_cnt;
	logic [1:0] rot;

	function automatic logic [1:0] bank_delay(input int b, input logic spread, input logic [1:0] r);
		int d;
		d = (b + int'(r)) % NUM_BANKS;
		if (spread) begin
			return 2'(d);
		end
		return (b == 0) ? FIXED_DELAY_FIRST : FIXED_DELAY_OTHER;
	endfunction

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			staged <= '0;
			stb <= '0;
			clk_pipe <= '0;
			word_cnt <= '0;
			rot <= '0;
			lock_d <= 1'b0;
			data_valid <= 1'b0;
			test_pass <= 1'b0;
			recovered_clock_out <= 1'b0;
		end else begin
			stb <= {stb[STAGGER_PIPE-2:0], rx_edge};
			clk_pipe <= {clk_pipe[STAGGER_PIPE-2:0], rx_clk_s};
			if (rx_edge) begin
				staged <= next_staged;
				word_cnt <= word_cnt + 2'h1;
				if (word_cnt == SPREAD_WORDS_LAST) begin
					rot <= (rot == ROT_LAST) ? 2'h0 : rot + 2'h1;
				end
			end
			lock_d <= lock_s;
			data_valid <= lock_s;
			test_pass <= pass & lock_s;
			recovered_clock_out <= clk_pipe[spread_s ? RCLK_DELAY_SPREAD : RCLK_DELAY_FIXED];
		end
	end

	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		wire logic [1:0] dly = bank_delay(b, spread_s, rot);
		always_ff @(posedge clk_sys) begin
			if (!reset_n) begin
				parallel_out[b*BANK_W +: BANK_W] <= '0;
			end else if (stb[dly]) begin
				parallel_out[b*BANK_W +: BANK_W] <= staged[b*BANK_W +: BANK_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts and APB slave.

	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	wire logic [IRQ_W-1:0] irq_events = {lock_fall, word_err, pass_hit};
	wire logic apb_setup = psel & penable & ~pready;
	wire logic apb_done = psel & penable & pready;
	wire logic wr_done = apb_done & pwrite;
	wire logic hit_status = (paddr == REG_STATUS);
	wire logic hit_irq_st = (paddr == REG_IRQ_STATUS);
	wire logic hit_irq_clr = (paddr == REG_IRQ_CLEAR);
	wire logic hit_irq_en = (paddr == REG_IRQ_ENABLE);
	wire logic hit_pass = (paddr == REG_PASS_WORDS);
	wire logic mapped = hit_status | hit_irq_st | hit_irq_clr | hit_irq_en | hit_pass;
	wire logic [DATA_W-1:0] status_word = {{(DATA_W-ST_CNT_LSB-CNT_W){1'b0}}, err_count,
		{(ST_CNT_LSB-ST_TEST-1){1'b0}}, test_s, lock_s, test_pass};
	wire logic [IRQ_W-1:0] clear_mask = (wr_done && hit_irq_clr) ? pwdata[IRQ_W-1:0] : '0;
	wire logic [DATA_W-1:0] read_word =
		hit_status ? status_word :
		hit_irq_st ? {{(DATA_W-IRQ_W){1'b0}}, irq_status} :
		hit_irq_en ? {{(DATA_W-IRQ_W){1'b0}}, irq_enable} :
		hit_pass ? pass_words : '0;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			irq_status <= '0;
			irq_enable <= '0;
			pass_words <= 32'(PASS_WORDS_DEFAULT);
			irq <= 1'b0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~mapped;
			prdata <= (apb_setup && !pwrite) ? read_word : '0;
			irq_status <= (irq_status & ~clear_mask) | irq_events;
			if (wr_done && hit_irq_en) irq_enable <= pwdata[IRQ_W-1:0];
			if (wr_done && hit_pass) pass_words <= pwdata;
			irq <= |(irq_status & irq_enable);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	AST_VALID_FOLLOWS_LOCK: assert property (data_valid == $past(lock_s))
		else $error("data_valid does not follow lock");
	AST_PASS_NEEDS_LOCK: assert property (test_pass |-> $past(lock_s) && $past(pass))
		else $error("test_pass high without lock");
	AST_PASS_LOW_OFF: assert property (!test_s |-> ##3 !test_pass)
		else $error("test_pass high outside self-test");
	AST_COUNT_MONOTONIC: assert property (checking && $past(checking) |-> err_count >= $past(err_count))
		else $error("error count decreased during self-test");
	AST_TX_PATTERN: assert property (tx_edge && test_s |=> tx_word == slb_step($past(tx_gen_word)))
		else $error("transmitter did not send the test pattern");
	AST_TX_BYPASS: assert property (tx_edge && !test_s && descr_off_s |=> tx_word == $past(tx_data_s))
		else $error("scramble bypass not honoured");
	AST_ERR_FLAGS: assert property (rx_edge && checking && test_s && !count_mode_s
		|=> staged == $past(rx_data_s ^ rx_pred))
		else $error("per-bit error flags wrong");
	AST_FIXED_BANKS: assert property (!spread_s && $past(!spread_s) && stb[1] && !stb[0] && !stb[2]
		|=> parallel_out[WORD_W-1:BANK_W] == $past(staged[WORD_W-1:BANK_W]))
		else $error("fixed stagger upper banks did not switch");
	AST_SPREAD_ROTATE: assert property (rx_edge && word_cnt == SPREAD_WORDS_LAST |=> rot != $past(rot))
		else $error("stagger arrangement did not rotate");
	AST_IRQ_LEVEL: assert property (irq == $past(|(irq_status & irq_enable)))
		else $error("interrupt output wrong");

endmodule // slb_top

// ---- test_slb_top.sv ----
// Self-checking bench for the link self-test block with a word-level reference model.
module test_slb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import slb_pkg::*;
	logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, transmit_clock, rx_lock, link_clock;
	logic self_test_enable, error_report_select, output_stagger_select, scramble_disable;
	logic recovered_clock_out, data_valid, test_pass, irq, run, lock_in, err, rp;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [WORD_W-1:0] parallel_in, tx_word, rx_word, parallel_out, err_mask, pm, po, t, pw;
	int n_fail, comparisons, cyc, c0, c1, c2, cnt, skip, cr;
	logic [23:0] q[$];
	slb_top #(.PASS_WORDS_DEFAULT(20)) i_slb_top (.clk_sys, .reset_n, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .transmit_clock, .parallel_in, .tx_word,
		.link_clock, .rx_word, .rx_lock, .self_test_enable, .error_report_select,
		.output_stagger_select, .scramble_disable, .parallel_out, .recovered_clock_out,
		.data_valid, .test_pass, .irq);
	slb_far_end i_slb_far_end (.run, .lock_in, .err_mask, .link_clock, .rx_word, .rx_lock);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////
	task test_done();
		if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [23:0] nx(input logic [23:0] s);
		for (int i = 0; i < WORD_W; i++) s = {s[22:0], ^(s & LFSR_TAPS)};
		return s;
	endfunction
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// The transmit clock pulses slowly enough for the synchroniser to see every edge.
	task tx(input logic [23:0] d);
		parallel_in <= d;
		repeat (4) @(posedge clk_sys);
		transmit_clock <= 1'b1;
		repeat (8) @(posedge clk_sys);
		transmit_clock <= 1'b0;
	endtask
	// Kinds of error mask: 0 none, 1 all bits flipped from the last word, 2 random, 3 all bits.
	task wd(input int n, input int k);
		repeat (n) begin
			@(posedge link_clock);
			err_mask = k == 0 ? 24'h0 : k == 1 ? ~err_mask : k == 3 ? 24'hffffff : 24'($urandom);
		end
	endtask
	////////////////////////////////////////
	always @(posedge clk_sys) begin
		cyc++;
		if (parallel_out[7:0] !== po[7:0]) c0 = cyc;
		if (parallel_out[15:8] !== po[15:8]) c1 = cyc;
		if (parallel_out[23:16] !== po[23:16]) c2 = cyc;
		if (recovered_clock_out && !rp) cr = cyc;
		rp = recovered_clock_out;
		po = parallel_out;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	always @(negedge link_clock or posedge run) if (run) q.push_back(err_mask);
	// A word's result is on the outputs by the next link clock rise.
	always @(posedge link_clock) begin
		if (q.size() >= 2 && lock_in) begin
			t = q.pop_front();
			cnt = (cnt + $countones(t) > 255) ? 255 : cnt + $countones(t);
			if (skip > 0) skip--;
			else if (!self_test_enable) chk("plain", pw, parallel_out);
			else if (error_report_select) chk("count", cnt, parallel_out[7:0]);
			else begin
				chk("flags", t, parallel_out);
				if ((t ^ pm) == 24'hffffff && output_stagger_select) begin
					chk("spread", 1, c0 != c1 && c1 != c2 && c0 != c2);
					chk("rclk_spread", (c0 > c1 ? (c0 > c2 ? c0 : c2) : (c1 > c2 ? c1 : c2)) + 1, cr);
				end else if ((t ^ pm) == 24'hffffff) begin
					chk("bank0", c1 + 1, c0);
					chk("bank2", c1, c2);
					chk("rclk_fixed", c1 - 1, cr);
				end
			end
			pm = t;
		end
		pw = rx_word;
	end
	////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, transmit_clock, self_test_enable, error_report_select} = '0;
		{output_stagger_select, scramble_disable, run, lock_in, reset_n} = '0;
		paddr = '0;
		pwdata = '0;
		parallel_in = '0;
		{err_mask, pm, po, pw} = '0;
		{cnt, skip, cyc, n_fail, comparisons, cr} = '0;
		rp = 1'b0;
		void'($urandom(32'hc87ca7e5));
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		#1 chk("reset", 0, {parallel_out, test_pass, irq, data_valid});
		apb(0, REG_IRQ_ENABLE, 0);
		chk("irq_enable", 0, rd);
		apb(0, REG_PASS_WORDS, 0);
		chk("pass_words", 20, rd);
		apb(1, REG_STATUS, 32'hffffffff);
		apb(0, REG_STATUS, 0);
		chk("status_ro", 0, rd);
		apb(0, 12'h100, 0);
		chk("unmapped", 0, rd);
		chk("slverr", 1, err);
		apb(1, REG_PASS_WORDS, 10);
		apb(1, REG_IRQ_ENABLE, 2);
		scramble_disable <= 1'b1;
		repeat (3) begin
			t = 24'($urandom);
			tx(t);
			chk("tx_plain", t, tx_word);
		end
		scramble_disable <= 1'b0;
		tx(t);
		chk("tx_scr", 1, tx_word !== t);
		self_test_enable <= 1'b1;
		tx(24'h0);
		t = tx_word;
		repeat (3) begin
			tx(24'h0);
			chk("tx_prbs", nx(t), tx_word);
			t = tx_word;
		end
		q.delete();
		skip = 3;
		run = 1'b1;
		lock_in = 1'b1;
		repeat (8) @(posedge clk_sys);
		chk("valid", 1, data_valid);
		wd(4, 0);
		wd(6, 1);
		wd(6, 2);
		wd(4, 0);
		chk("pass_early", 0, test_pass);
		wd(12, 0);
		chk("pass", 1, test_pass);
		apb(0, REG_IRQ_STATUS, 0);
		chk("irq_status", 3, rd);
		chk("irq", 1, irq);
		apb(1, REG_IRQ_CLEAR, 2);
		apb(0, REG_IRQ_STATUS, 0);
		chk("irq_clear", 1, rd);
		chk("irq_mask", 0, irq);
		apb(1, REG_IRQ_ENABLE, 1);
		apb(0, REG_STATUS, 0);
		chk("status", {16'h0, cnt[7:0], 8'h07}, rd);
		chk("irq_on", 1, irq);
		output_stagger_select <= 1'b1;
		wd(3, 0);
		wd(10, 1);
		error_report_select <= 1'b1;
		skip = 2;
		wd(4, 2);
		wd(12, 3);
		wd(3, 0);
		run = 1'b0;
		lock_in = 1'b0;
		repeat (8) @(posedge clk_sys);
		chk("valid_off", 0, data_valid);
		chk("pass_off", 0, test_pass);
		self_test_enable <= 1'b0;
		apb(0, REG_IRQ_STATUS, 0);
		chk("lock_lost", 1, rd[IRQ_LOCK_LOST]);
		apb(0, REG_STATUS, 0);
		chk("test_off", 0, rd[ST_TEST]);
		// Normal traffic with scrambling bypassed must come out unchanged.
		scramble_disable <= 1'b1;
		q.delete();
		skip = 3;
		run = 1'b1;
		lock_in = 1'b1;
		wd(7, 0);
		test_done();
	end
endmodule // test_slb_top
